//--- inc/alarm_flags_defs.svh
// constants for the alarm flag register bank and its serial port
`ifndef ALARM_FLAGS_DEFS_SVH
`define ALARM_FLAGS_DEFS_SVH

// register addresses on the serial port
`define REG_OVERVIEW      7'h10
`define REG_TRIP_CH0_3    7'h11
`define REG_ACT_CH0_3     7'h12
`define REG_TRIP_CH4_7    7'h13
`define REG_ACT_CH4_7     7'h14

// reset and fill values
`define FLAGS_RESET       8'h00
`define ABSENT_READ       8'hff
`define UNMAPPED_READ     8'h00

// serial frame layout, first bit on sdi is bit 15
`define FRAME_BITS        16
`define FRAME_LAST        4'hf
`define FRAME_ADDR_MSB    15
`define FRAME_ADDR_LSB    9
`define FRAME_WR_BIT      8
`define FRAME_DATA_BITS   8

// channel counts
`define MAX_CHANNELS      8
`define GROUP_CHANNELS    4

`endif

//--- inc/alarm_flags_pkg.sv
// types shared by the alarm flag register bank
package alarm_flags_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [6:0] addr_t;

    // which kind of register the last read frame fetched
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_TRIP_LOW_GROUP,
        SEL_TRIP_HIGH_GROUP,
        SEL_OTHER
    } sel_t;

endpackage : alarm_flags_pkg

//--- hdl/sync3.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module sync3 (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // asynchronous level in, filtered level out
    input  wire logic din,
    output logic      dout
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // stage one feeds stage two only, so no logic sees a metastable value
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change is accepted only when two settled stages agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dout <= 1'b0;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end

endmodule : sync3

`default_nettype wire

//--- hdl/serial_link.sv
// serial port logic on the link clock: command capture and read data shift-out
`timescale 1ns/100ps
`default_nettype none
`include "alarm_flags_defs.svh"

module serial_link (
    // link side
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  sdi,
    output logic                       sdo,
    output logic                       sdo_oe,
    // core reset, used as an asynchronous clear here
    input  wire logic                  nrst,
    // word fetched by the core for the coming frame, held steady
    input  wire alarm_flags_pkg::byte_t rd_word,
    // command of the last whole frame, held until the next frame ends
    output alarm_flags_pkg::addr_t     cmd_addr,
    output logic                       cmd_wr,
    output logic                       frame_tgl
);

    logic [3:0]                  bit_cnt_r;
    logic [`FRAME_BITS-1:0]      rx_r;
    logic [`FRAME_BITS-1:0]      rx_nxt;
    alarm_flags_pkg::byte_t      tx_r;
    logic                        frame_clr;
    logic                        link_clr;

    // the link clock stops between frames, so framing clears asynchronously
    assign frame_clr = cs_n | ~nrst;
    assign link_clr  = ~nrst;
    assign rx_nxt    = {rx_r[`FRAME_BITS-2:0], sdi};

    // bit position inside the frame
    always_ff @(posedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            bit_cnt_r <= 4'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // command bits shift in msb first
    always_ff @(posedge sclk or posedge link_clr) begin
        if (link_clr) begin
            rx_r <= 16'h0000;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    // read data load on the first edge, then shift out; zeros follow
    always_ff @(posedge sclk or posedge link_clr) begin
        if (link_clr) begin
            tx_r <= 8'h00;
        end else if (bit_cnt_r == 4'h0) begin
            tx_r <= rd_word;
        end else begin
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // the frame's own last edge hands command and shift-out over to the core
    always_ff @(posedge sclk or posedge link_clr) begin
        if (link_clr) begin
            cmd_addr  <= 7'h00;
            cmd_wr    <= 1'b0;
            frame_tgl <= 1'b0;
        end else if (bit_cnt_r == `FRAME_LAST) begin
            cmd_addr  <= rx_nxt[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
            cmd_wr    <= rx_nxt[`FRAME_WR_BIT];
            frame_tgl <= ~frame_tgl;
        end
    end

    assign sdo    = tx_r[7];
    assign sdo_oe = ~cs_n;

endmodule : serial_link

`default_nettype wire

//--- hdl/alarm_flag_bank.sv
// alarm flag register bank: active and tripped flags, overview and serial readout
`timescale 1ns/100ps
`default_nettype none
`include "alarm_flags_defs.svh"

// How it works
// - each channel has a high and a low threshold, each with an active and a tripped flag.
// - an active flag follows the live crossing of its threshold, set only while it lasts.
// - a tripped flag sets with its active flag and stays latched until the host reads it.
// - all eight channels' flags sit in the four read-only registers 11h to 14h.
// - the overview register holds one tripped bit per channel, bit n for channel n.
// - register 11h holds channels 0-3 tripped flags, low then high per channel from bit 7.
// - register 12h holds channels 0-3 active flags in the same order as 11h.
// - register 13h holds channels 4-7 tripped flags, low then high per channel from bit 7.
// - every flag reads 1 for an alarm and 0 for none, and all flags reset to zero.
// - in the four-channel build writes to absent channels change nothing.
// - in the four-channel build reads of absent bits or registers return all ones.
// - each overview bit of a present channel is the OR of its channel's high and low tripped flags.
// - an alarm pin tells the host a flag tripped, so it can go and read the flags.
// - register 14h holds channels 4-7 active flags in the same order as 13h.
module alarm_flag_bank #(
    parameter int CHANNELS = 8
) (
    // core clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // comparator results from the conversion path, same clock
    input  wire logic       conv_valid,
    input  wire logic [7:0] high_cross,
    input  wire logic [7:0] low_cross,
    // alarm pin
    output logic            alarm_out,
    // serial port
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdo_oe
);

    // flag state, one bit per channel
    logic [7:0]                 present;
    logic [7:0]                 act_hi_r;
    logic [7:0]                 act_lo_r;
    logic [7:0]                 trip_hi_r;
    logic [7:0]                 trip_lo_r;
    logic [7:0]                 trip_hi_nxt;
    logic [7:0]                 trip_lo_nxt;
    logic [7:0]                 set_hi;
    logic [7:0]                 set_lo;
    logic [7:0]                 clr_hi;
    logic [7:0]                 clr_lo;

    // register images
    alarm_flags_pkg::byte_t     overview;
    alarm_flags_pkg::byte_t     trip03;
    alarm_flags_pkg::byte_t     act03;
    alarm_flags_pkg::byte_t     trip47;
    alarm_flags_pkg::byte_t     act47;
    alarm_flags_pkg::byte_t     read_val;
    alarm_flags_pkg::sel_t      read_sel;

    // snapshot that the next frame shifts out
    alarm_flags_pkg::byte_t     snap_r;
    alarm_flags_pkg::sel_t      snap_sel_r;

    // crossing from the link domain
    alarm_flags_pkg::addr_t     cmd_addr;
    logic                       cmd_wr;
    logic                       frame_tgl;
    logic                       frame_lvl;
    logic                       frame_seen_r;
    logic                       frame_evt;

    // channels beyond the build's count are tied off
    genvar c;
    generate
        for (c = 0; c < `MAX_CHANNELS; c++) begin : g_present
            assign present[c] = (c < CHANNELS);
        end
    endgenerate

    // a new crossing only counts on a conversion of a present channel
    assign set_hi = {8{conv_valid}} & high_cross & present;
    assign set_lo = {8{conv_valid}} & low_cross & present;

    // active flags follow the comparator at each conversion result
    always_ff @(posedge clk) begin
        if (!nrst) begin
            act_hi_r <= `FLAGS_RESET;
            act_lo_r <= `FLAGS_RESET;
        end else if (conv_valid) begin
            act_hi_r <= high_cross & present;
            act_lo_r <= low_cross & present;
        end
    end

    // latching: a set arriving with a clear wins, so no alarm is lost
    assign trip_hi_nxt = (trip_hi_r & ~clr_hi) | set_hi;
    assign trip_lo_nxt = (trip_lo_r & ~clr_lo) | set_lo;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            trip_hi_r <= `FLAGS_RESET;
            trip_lo_r <= `FLAGS_RESET;
        end else begin
            trip_hi_r <= trip_hi_nxt;
            trip_lo_r <= trip_lo_nxt;
        end
    end

    // pack the per-channel bits: low at the odd bit, high just below it
    genvar k;
    generate
        for (k = 0; k < `GROUP_CHANNELS; k++) begin : g_pack
            assign trip03[2*(3-k)+1] = trip_lo_r[k];
            assign trip03[2*(3-k)]   = trip_hi_r[k];
            assign act03[2*(3-k)+1]  = act_lo_r[k];
            assign act03[2*(3-k)]    = act_hi_r[k];
            assign trip47[2*(3-k)+1] = trip_lo_r[k+4];
            assign trip47[2*(3-k)]   = trip_hi_r[k+4];
            assign act47[2*(3-k)+1]  = act_lo_r[k+4];
            assign act47[2*(3-k)]    = act_hi_r[k+4];
        end
    endgenerate

    // overview: absent channels read as ones, present ones as the OR
    assign overview = (trip_hi_r | trip_lo_r) | ~present;

    // read decode; all registers are read-only so a write only discards
    always_comb begin
        read_val = `UNMAPPED_READ;
        read_sel = alarm_flags_pkg::SEL_NONE;
        if (!cmd_wr) begin
            case (cmd_addr)
                `REG_OVERVIEW: begin
                    read_val = overview;
                    read_sel = alarm_flags_pkg::SEL_OTHER;
                end
                `REG_TRIP_CH0_3: begin
                    read_val = trip03;
                    read_sel = alarm_flags_pkg::SEL_TRIP_LOW_GROUP;
                end
                `REG_ACT_CH0_3: begin
                    read_val = act03;
                    read_sel = alarm_flags_pkg::SEL_OTHER;
                end
                `REG_TRIP_CH4_7: begin
                    if (CHANNELS > `GROUP_CHANNELS) begin
                        read_val = trip47;
                        read_sel = alarm_flags_pkg::SEL_TRIP_HIGH_GROUP;
                    end else begin
                        read_val = `ABSENT_READ;
                        read_sel = alarm_flags_pkg::SEL_OTHER;
                    end
                end
                `REG_ACT_CH4_7: begin
                    if (CHANNELS > `GROUP_CHANNELS) begin
                        read_val = act47;
                    end else begin
                        read_val = `ABSENT_READ;
                    end
                    read_sel = alarm_flags_pkg::SEL_OTHER;
                end
                default: begin
                    read_val = `UNMAPPED_READ;
                    read_sel = alarm_flags_pkg::SEL_NONE;
                end
            endcase
        end
    end

    // frame end event: toggle crosses through the three-stage synchroniser
    sync3 u_frame_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (frame_tgl),
        .dout (frame_lvl)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            frame_seen_r <= 1'b0;
        end else begin
            frame_seen_r <= frame_lvl;
        end
    end

    assign frame_evt = (frame_lvl != frame_seen_r);

    // snapshot is fetched once per frame; the link loads it at the next frame start
    // limitation: the host must leave a gap between frames so this has settled
    always_ff @(posedge clk) begin
        if (!nrst) begin
            snap_r     <= `UNMAPPED_READ;
            snap_sel_r <= alarm_flags_pkg::SEL_NONE;
        end else if (frame_evt) begin
            snap_r     <= read_val;
            snap_sel_r <= read_sel;
        end
    end

    // clear only the tripped bits that the finished frame returned as ones
    // the event also marks the end of the frame that shifted the snapshot out
    always_comb begin
        clr_hi = 8'h00;
        clr_lo = 8'h00;
        for (int i = 0; i < `GROUP_CHANNELS; i++) begin
            if (frame_evt && snap_sel_r == alarm_flags_pkg::SEL_TRIP_LOW_GROUP) begin
                clr_lo[i] = snap_r[2*(3-i)+1];
                clr_hi[i] = snap_r[2*(3-i)];
            end
            if (frame_evt && snap_sel_r == alarm_flags_pkg::SEL_TRIP_HIGH_GROUP) begin
                clr_lo[i+4] = snap_r[2*(3-i)+1];
                clr_hi[i+4] = snap_r[2*(3-i)];
            end
        end
    end

    // alarm pin raised while any present tripped flag stands
    always_ff @(posedge clk) begin
        if (!nrst) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= |(trip_hi_nxt | trip_lo_nxt);
        end
    end

    // link-side framing on its own clock
    serial_link u_link (
        .sclk      (sclk),
        .cs_n      (cs_n),
        .sdi       (sdi),
        .sdo       (sdo),
        .sdo_oe    (sdo_oe),
        .nrst      (nrst),
        .rd_word   (snap_r),
        .cmd_addr  (cmd_addr),
        .cmd_wr    (cmd_wr),
        .frame_tgl (frame_tgl)
    );

endmodule : alarm_flag_bank

`default_nettype wire

//--- test/alarm_flag_bank_properties.sv
// port assertions for the alarm flag bank
`timescale 1ns/100ps
`default_nettype none

module alarm_flag_bank_properties #(
    parameter int CHANNELS = 8
) (
    // core side
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       conv_valid,
    input wire logic [7:0] high_cross,
    input wire logic [7:0] low_cross,
    input wire logic       alarm_out,
    // serial side
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       sdi,
    input wire logic       sdo,
    input wire logic       sdo_oe
);
    localparam logic [7:0] CH_MASK = (CHANNELS >= 8) ? 8'hff : 8'h0f;
    logic [4:0] edge_cnt_r;
    logic       hit;

    // only crossings of channels that exist may raise the pin
    assign hit = |((high_cross | low_cross) & CH_MASK);

    // rising sclk edges in this frame; deselect clears it without a clock
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt_r <= 5'h00;
        end else if (edge_cnt_r != 5'h1f) begin
            edge_cnt_r <= edge_cnt_r + 5'h01;
        end
    end

    a_alarm_sets: assert property (@(posedge clk) disable iff (!nrst)
        conv_valid && hit |=> alarm_out) else $error("alarm pin not raised");
    a_alarm_needs_conv: assert property (@(posedge clk) disable iff (!nrst)
        !alarm_out && !conv_valid |=> !alarm_out) else $error("alarm rose without result");
    a_absent_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !alarm_out && conv_valid && !hit |=> !alarm_out) else $error("absent channel alarmed");
    a_alarm_latched: assert property (@(posedge clk) disable iff (!nrst)
        alarm_out && !conv_valid && !cs_n |=> alarm_out) else $error("tripped lost in frame");
    a_reset_clears: assert property (@(posedge clk)
        !nrst |=> !alarm_out) else $error("alarm set in reset");
    a_sdo_reset: assert property (@(posedge clk)
        !nrst |-> !sdo) else $error("sdo set in reset");
    a_oe_select: assert property (@(posedge clk) disable iff (!nrst)
        sdo_oe == !cs_n) else $error("sdo enable not following select");
    a_oe_in_frame: assert property (@(posedge sclk) disable iff (!nrst)
        !cs_n |-> sdo_oe) else $error("sdo not driven in frame");
    a_sdo_tail: assert property (@(posedge sclk) disable iff (!nrst)
        !cs_n && edge_cnt_r >= 5'h09 |-> !sdo) else $error("sdo not low after byte");

    c_alarm: cover property (@(posedge clk) disable iff (!nrst) $rose(alarm_out));
    c_clear: cover property (@(posedge clk) disable iff (!nrst) $fell(alarm_out));
    c_frame: cover property (@(posedge sclk) disable iff (!nrst) edge_cnt_r == 5'h10);
endmodule : alarm_flag_bank_properties

bind alarm_flag_bank alarm_flag_bank_properties #(.CHANNELS(CHANNELS)) i_props (
    .clk(clk), .nrst(nrst), .conv_valid(conv_valid), .high_cross(high_cross),
    .low_cross(low_cross), .alarm_out(alarm_out), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

`default_nettype wire

//--- test/host_model.sv
// host controller model: frames on the serial port of two devices at once
`timescale 1ns/100ps
`default_nettype none

module host_model (
    // lines driven by the host
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    // data lines of the two devices
    input  wire logic sdo_a,
    input  wire logic sdo_b
);
    // idle: deselected, clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // one 16-bit frame at 6 ns; sdi moves on falling edges, sdo read there
    task automatic xfer(input alarm_flags_pkg::addr_t addr, input logic wr,
                        input alarm_flags_pkg::byte_t data,
                        output alarm_flags_pkg::byte_t got_a,
                        output alarm_flags_pkg::byte_t got_b);
        logic [15:0] word;
        word = {addr, wr, data};
        cs_n = 1'b0;
        sdi  = word[15];
        for (int k = 0; k < 16; k++) begin
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
            if (k < 8) begin
                got_a[7-k] = sdo_a;
                got_b[7-k] = sdo_b;
            end
            if (k < 15) begin
                sdi = word[14-k];
            end
        end
        #3 cs_n = 1'b1;
        sdi = ~sdi; // a released line must not keep its last value
    endtask : xfer
endmodule : host_model

`default_nettype wire

//--- test/tb_top.sv
// bench for the alarm flag bank, eight- and four-channel builds side by side
`timescale 1ns/100ps
`default_nettype none
`include "alarm_flags_defs.svh"

module tb_top;
    logic                   clk;
    logic                   nrst;
    logic                   conv_valid;
    logic [7:0]             high_cross;
    logic [7:0]             low_cross;
    logic                   sclk;
    logic                   cs_n;
    logic                   sdi;
    logic                   sdo;
    logic                   sdo4;
    logic                   alarm8;
    logic                   alarm4;
    int                     num_errors;
    int                     check_count;
    alarm_flags_pkg::byte_t d8;
    alarm_flags_pkg::byte_t d4;
    alarm_flags_pkg::addr_t ra [6] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h20};
    alarm_flags_pkg::byte_t r4 [6] = '{8'hf0, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};

    alarm_flag_bank #(.CHANNELS(8)) i_dut (.clk(clk), .nrst(nrst), .conv_valid(conv_valid),
        .high_cross(high_cross), .low_cross(low_cross), .alarm_out(alarm8), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe());
    alarm_flag_bank #(.CHANNELS(4)) i_dut4 (.clk(clk), .nrst(nrst), .conv_valid(conv_valid),
        .high_cross(high_cross), .low_cross(low_cross), .alarm_out(alarm4), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo4), .sdo_oe());
    host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_a(sdo), .sdo_b(sdo4));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic chk(input alarm_flags_pkg::byte_t got, input alarm_flags_pkg::byte_t exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // a byte comes back one frame after its command, so a read costs two frames
    task automatic rd(input alarm_flags_pkg::addr_t a, input alarm_flags_pkg::byte_t e8,
                      input alarm_flags_pkg::byte_t e4);
        i_host.xfer(a, 1'b0, 8'h00, d8, d4);
        repeat (10) @(posedge clk);
        i_host.xfer(7'h10, 1'b0, 8'h00, d8, d4);
        repeat (10) @(posedge clk);
        chk(d8, e8);
        chk(d4, e4);
    endtask : rd

    // one conversion result, driven at the falling edge
    task automatic conv(input alarm_flags_pkg::byte_t hi, input alarm_flags_pkg::byte_t lo);
        @(negedge clk);
        conv_valid = 1'b1;
        high_cross = hi;
        low_cross  = lo;
        @(negedge clk);
        conv_valid = 1'b0;
    endtask : conv

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // hang guard, far beyond the roughly 7.9 us that the run takes
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    initial begin
        num_errors  = 0;
        check_count = 0;
        nrst        = 1'b0;
        conv_valid  = 1'b0;
        high_cross  = 8'h00;
        low_cross   = 8'h00;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 6; i++) rd(ra[i], 8'h00, r4[i]);
        // writes to read-only and absent places must change nothing
        i_host.xfer(7'h13, 1'b1, 8'hff, d8, d4);
        repeat (10) @(posedge clk);
        i_host.xfer(7'h11, 1'b1, 8'hff, d8, d4);
        repeat (10) @(posedge clk);
        rd(7'h13, 8'h00, 8'hff);
        rd(7'h11, 8'h00, 8'h00);
        // ch2 high, ch0 low, ch7 low, then the condition goes away
        conv(8'h04, 8'h81);
        chk({7'h00, alarm8}, 8'h01);
        chk({7'h00, alarm4}, 8'h01);
        conv(8'h00, 8'h00);
        rd(7'h12, 8'h00, 8'h00);
        rd(7'h10, 8'h85, 8'hf5);
        rd(7'h11, 8'h84, 8'h84);
        rd(7'h11, 8'h00, 8'h00);
        rd(7'h13, 8'h02, 8'hff);
        rd(7'h13, 8'h00, 8'hff);
        chk({7'h00, alarm8}, 8'h00);
        // ch4 high and ch3 low held across conversions
        conv(8'h10, 8'h08);
        rd(7'h12, 8'h02, 8'h02);
        rd(7'h14, 8'h40, 8'hff);
        rd(7'h11, 8'h02, 8'h02);
        conv(8'h10, 8'h08);
        rd(7'h11, 8'h02, 8'h02);
        conv(8'h00, 8'h00);
        rd(7'h12, 8'h00, 8'h00);
        rd(7'h11, 8'h00, 8'h00);
        rd(7'h13, 8'h40, 8'hff);
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
